// file: common/srcp_map.svh
`ifndef SRCP_MAP_SVH
`define SRCP_MAP_SVH

// ----------------------------------------------------------------------------
// clock and serial rates
// ----------------------------------------------------------------------------
`define SRCP_CLK_HZ     200000000
`define SRCP_BAUD_SLOW  56700
`define SRCP_BAUD_FAST  115200
`define SRCP_BIT_SLOW   (`SRCP_CLK_HZ / `SRCP_BAUD_SLOW)
`define SRCP_BIT_FAST   (`SRCP_CLK_HZ / `SRCP_BAUD_FAST)

// ----------------------------------------------------------------------------
// character and command framing
// ----------------------------------------------------------------------------
`define SRCP_DATA_BITS  4'h8
`define SRCP_STOP_POS   4'h9
`define SRCP_ACK_BYTE   8'h02
`define SRCP_REPLY_CNT  4'h8
`define SRCP_WIN_FIRST  8'h00
`define SRCP_WIN_LAST   8'hff

`endif

// file: common/srcp_pkg.sv
package srcp_pkg;

  typedef enum logic [2:0] {
    SRCP_ADDR,
    SRCP_LEN,
    SRCP_DATA,
    SRCP_EXEC,
    SRCP_SEND
  } srcp_state_t;

endpackage : srcp_pkg

// file: logic/srcp_mem.sv
`timescale 1ns/1ps
`default_nettype none

module srcp_mem
(
  // clock
  input  wire logic       sys_clk,
  input  wire logic       ce,
  // write side
  input  wire logic       wr_en,
  input  wire logic [2:0] wr_idx,
  input  wire logic [7:0] wr_byte,
  // read side
  input  wire logic [2:0] rd_idx,
  output var  logic [7:0] rd_byte_q
);

  logic [7:0] mem_q [8];

  always_ff @(posedge sys_clk)
  begin
    if (ce)
    begin
      if (wr_en)
      begin
        mem_q[wr_idx] <= wr_byte;
      end
      rd_byte_q <= mem_q[rd_idx];
    end
  end

endmodule : srcp_mem

`default_nettype wire

// file: logic/srcp_top.sv
// Contract
// - at reset release, strap high selects 56700 baud, low selects 115200.
// - characters are 8 data bits, no parity, one stop bit, both ways.
// - only transmit and receive lines; no handshake paces the transfer.
// - after the address byte, collect all data bytes before executing.
// - after a configuration command, send one acknowledge byte with bit 1 set.
// - each query returns exactly eight reply bytes, most significant first.
// - bridge interface is a window at offsets 0x00 to 0xFF.
`timescale 1ns/1ps
`default_nettype none
`include "srcp_map.svh"

module srcp_top
  import srcp_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // serial pins
  input  wire logic        rx_pin,
  input  wire logic        rate_sel_pin,
  output var  logic        tx_pin_q,
  // command to register logic
  output var  logic [7:0]  cmd_addr_q,
  input  wire logic [2:0]  cmd_len,
  input  wire logic        cmd_query,
  output var  logic        exec_q,
  input  wire logic [2:0]  cmd_rd_idx,
  output var  logic [7:0]  cmd_rd_byte_q,
  input  wire logic        exec_done,
  input  wire logic [63:0] reply_data,
  // status
  output var  logic        busy_q,
  output var  logic        fast_rate_q,
  output var  logic        frame_err_q,
  output var  logic        rx_drop_q
);

  function automatic logic [11:0] bit_len(input logic fast);
    bit_len = fast ? 12'(`SRCP_BIT_FAST - 1) : 12'(`SRCP_BIT_SLOW - 1);
  endfunction : bit_len

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n || !ce);

  // --------------------------------------------------------------------------
  // pin synchronisers and rate strap
  // --------------------------------------------------------------------------
  logic       rx_s1_q, rx_s2_q, rx_prev_q, rs_s1_q, rs_s2_q, strap_done_q;
  logic [1:0] strap_cnt_q;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_s1_q      <= 1'b1;
      rx_s2_q      <= 1'b1;
      rx_prev_q    <= 1'b1;
      rs_s1_q      <= 1'b1;
      rs_s2_q      <= 1'b1;
      strap_done_q <= 1'b0;
      strap_cnt_q  <= 2'h0;
      fast_rate_q  <= 1'b0;
    end
    else if (ce)
    begin
      rx_s1_q   <= rx_pin;
      rx_s2_q   <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
      rs_s1_q   <= rate_sel_pin;
      rs_s2_q   <= rs_s1_q;
      // strap is caught once, after both stages hold the pin, not their reset value
      if (!strap_done_q)
      begin
        if (strap_cnt_q == 2'h2)
        begin
          strap_done_q <= 1'b1;
          fast_rate_q  <= !rs_s2_q;
        end
        else
        begin
          strap_cnt_q <= strap_cnt_q + 2'h1;
        end
      end
    end
  end

  a_rate_strap: assert property ($rose(strap_done_q) |-> fast_rate_q == !$past(rs_s2_q))
    else $error("rate strap not taken from synchronised pin");

  // --------------------------------------------------------------------------
  // receiver: 8N1, sampled mid bit
  // --------------------------------------------------------------------------
  logic        rx_busy_q, rx_busy_d, rx_vld_q, rx_vld_d, frame_err_d;
  logic [11:0] rx_cnt_q, rx_cnt_d;
  logic [3:0]  rx_bit_q, rx_bit_d;
  logic [7:0]  rx_sh_q, rx_sh_d;

  always_comb
  begin
    rx_busy_d   = rx_busy_q;
    rx_cnt_d    = rx_cnt_q;
    rx_bit_d    = rx_bit_q;
    rx_sh_d     = rx_sh_q;
    rx_vld_d    = 1'b0;
    frame_err_d = 1'b0;
    if (!rx_busy_q)
    begin
      if (strap_done_q && rx_prev_q && !rx_s2_q)
      begin
        rx_busy_d = 1'b1;
        rx_cnt_d  = bit_len(fast_rate_q) >> 1;
        rx_bit_d  = 4'h0;
      end
    end
    else if (rx_cnt_q != 12'h000)
    begin
      rx_cnt_d = rx_cnt_q - 12'h001;
    end
    else
    begin
      rx_cnt_d = bit_len(fast_rate_q);
      rx_bit_d = rx_bit_q + 4'h1;
      if (rx_bit_q == 4'h0)
      begin
        // glitch on the start bit: back to idle
        rx_busy_d = !rx_s2_q;
      end
      else if (rx_bit_q <= `SRCP_DATA_BITS)
      begin
        rx_sh_d = {rx_s2_q, rx_sh_q[7:1]};
      end
      else
      begin
        rx_busy_d   = 1'b0;
        rx_vld_d    = rx_s2_q;
        frame_err_d = !rx_s2_q;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_busy_q   <= 1'b0;
      rx_cnt_q    <= 12'h000;
      rx_bit_q    <= 4'h0;
      rx_sh_q     <= 8'h00;
      rx_vld_q    <= 1'b0;
      frame_err_q <= 1'b0;
    end
    else if (ce)
    begin
      rx_busy_q   <= rx_busy_d;
      rx_cnt_q    <= rx_cnt_d;
      rx_bit_q    <= rx_bit_d;
      rx_sh_q     <= rx_sh_d;
      rx_vld_q    <= rx_vld_d;
      frame_err_q <= frame_err_d;
    end
  end

  a_rx_stop_bit: assert property (rx_vld_q |-> $past(rx_s2_q) && $past(rx_bit_q) == `SRCP_STOP_POS)
    else $error("byte accepted without a valid stop bit");

  // --------------------------------------------------------------------------
  // transmitter: start, 8 data lsb first, stop
  // --------------------------------------------------------------------------
  logic        tx_go_q, tx_go_d, tx_busy_q, tx_busy_d, tx_pin_d;
  logic [7:0]  tx_byte_q, tx_byte_d;
  logic [11:0] tx_cnt_q, tx_cnt_d;
  logic [3:0]  tx_bit_q, tx_bit_d;
  logic [9:0]  tx_sh_q, tx_sh_d;

  always_comb
  begin
    tx_busy_d = tx_busy_q;
    tx_cnt_d  = tx_cnt_q;
    tx_bit_d  = tx_bit_q;
    tx_sh_d   = tx_sh_q;
    tx_pin_d  = tx_pin_q;
    if (!tx_busy_q)
    begin
      if (tx_go_q)
      begin
        tx_busy_d = 1'b1;
        tx_sh_d   = {1'b1, tx_byte_q, 1'b0};
        tx_bit_d  = 4'h0;
        tx_cnt_d  = bit_len(fast_rate_q);
        tx_pin_d  = 1'b0;
      end
    end
    else if (tx_cnt_q != 12'h000)
    begin
      tx_cnt_d = tx_cnt_q - 12'h001;
    end
    else if (tx_bit_q == `SRCP_STOP_POS)
    begin
      tx_busy_d = 1'b0;
    end
    else
    begin
      tx_bit_d = tx_bit_q + 4'h1;
      tx_sh_d  = {1'b1, tx_sh_q[9:1]};
      tx_pin_d = tx_sh_q[1];
      tx_cnt_d = bit_len(fast_rate_q);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_busy_q <= 1'b0;
      tx_cnt_q  <= 12'h000;
      tx_bit_q  <= 4'h0;
      tx_sh_q   <= 10'h3ff;
      tx_pin_q  <= 1'b1;
    end
    else if (ce)
    begin
      tx_busy_q <= tx_busy_d;
      tx_cnt_q  <= tx_cnt_d;
      tx_bit_q  <= tx_bit_d;
      tx_sh_q   <= tx_sh_d;
      tx_pin_q  <= tx_pin_d;
    end
  end

  a_tx_start_bit: assert property (tx_go_q && !tx_busy_q |=> !tx_pin_q && tx_busy_q)
    else $error("start bit missing");
  a_tx_stop_bit: assert property (tx_busy_q && tx_bit_q == `SRCP_STOP_POS |-> tx_pin_q)
    else $error("stop bit not high");

  // --------------------------------------------------------------------------
  // command sequencer
  // --------------------------------------------------------------------------
  srcp_state_t st_q, st_d;
  logic [2:0]  need_q, need_d, cnt_q, cnt_d;
  logic [3:0]  left_q, left_d;
  logic [63:0] rsp_q, rsp_d;
  logic [7:0]  cmd_addr_d;
  logic        query_q, query_d, exec_d, rx_drop_d;

  srcp_mem u_mem
  (
    .sys_clk   (sys_clk),
    .ce        (ce),
    .wr_en     (st_q == SRCP_DATA && rx_vld_q),
    .wr_idx    (cnt_q),
    .wr_byte   (rx_sh_q),
    .rd_idx    (cmd_rd_idx),
    .rd_byte_q (cmd_rd_byte_q)
  );

  always_comb
  begin
    st_d       = st_q;
    need_d     = need_q;
    cnt_d      = cnt_q;
    left_d     = left_q;
    rsp_d      = rsp_q;
    cmd_addr_d = cmd_addr_q;
    query_d    = query_q;
    exec_d     = 1'b0;
    tx_go_d    = 1'b0;
    tx_byte_d  = tx_byte_q;
    // no handshake: bytes outside collection are lost, not held off
    rx_drop_d  = rx_vld_q && st_q != SRCP_ADDR && st_q != SRCP_DATA;
    case (st_q)
      SRCP_ADDR:
        if (rx_vld_q)
        begin
          cmd_addr_d = rx_sh_q;
          st_d       = SRCP_LEN;
        end
      SRCP_LEN:
      begin
        need_d  = cmd_len;
        query_d = cmd_query;
        cnt_d   = 3'h0;
        if (cmd_len == 3'h0)
        begin
          exec_d = 1'b1;
          st_d   = SRCP_EXEC;
        end
        else
        begin
          st_d = SRCP_DATA;
        end
      end
      SRCP_DATA:
        if (rx_vld_q)
        begin
          cnt_d = cnt_q + 3'h1;
          if (cnt_q + 3'h1 == need_q)
          begin
            exec_d = 1'b1;
            st_d   = SRCP_EXEC;
          end
        end
      SRCP_EXEC:
        if (exec_done && !exec_q)
        begin
          rsp_d  = query_q ? reply_data : {`SRCP_ACK_BYTE, 56'h0};
          left_d = query_q ? `SRCP_REPLY_CNT : 4'h1;
          st_d   = SRCP_SEND;
        end
      SRCP_SEND:
        if (!tx_busy_q && !tx_go_q)
        begin
          tx_go_d   = 1'b1;
          tx_byte_d = rsp_q[63:56];
          rsp_d     = {rsp_q[55:0], 8'h00};
          left_d    = left_q - 4'h1;
          if (left_q == 4'h1)
          begin
            st_d = SRCP_ADDR;
          end
        end
      default:
        st_d = SRCP_ADDR;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q       <= SRCP_ADDR;
      need_q     <= 3'h0;
      cnt_q      <= 3'h0;
      left_q     <= 4'h0;
      rsp_q      <= 64'h0;
      cmd_addr_q <= 8'h00;
      query_q    <= 1'b0;
      exec_q     <= 1'b0;
      tx_go_q    <= 1'b0;
      tx_byte_q  <= 8'h00;
      rx_drop_q  <= 1'b0;
      busy_q     <= 1'b0;
    end
    else if (ce)
    begin
      st_q       <= st_d;
      need_q     <= need_d;
      cnt_q      <= cnt_d;
      left_q     <= left_d;
      rsp_q      <= rsp_d;
      cmd_addr_q <= cmd_addr_d;
      query_q    <= query_d;
      exec_q     <= exec_d;
      tx_go_q    <= tx_go_d;
      tx_byte_q  <= tx_byte_d;
      rx_drop_q  <= rx_drop_d;
      busy_q     <= st_d != SRCP_ADDR;
    end
  end

  a_exec_all_bytes: assert property (exec_q |-> cnt_q == need_q && st_q == SRCP_EXEC)
    else $error("command executed before all data bytes arrived");
  a_ack_byte: assert property (st_q == SRCP_EXEC && exec_done && !exec_q && !query_q
    |=> rsp_q[63:56] == `SRCP_ACK_BYTE && rsp_q[57] && left_q == 4'h1)
    else $error("acknowledge byte wrong");
  a_reply_count: assert property (st_q == SRCP_EXEC && exec_done && !exec_q && query_q
    |=> left_q == 4'h8 ##1 (left_q == 4'h7) [*1])
    else $error("query reply count not eight");
  a_reply_msb: assert property (st_q == SRCP_SEND && !tx_busy_q && !tx_go_q
    |=> tx_go_q && tx_byte_q == $past(rsp_q[63:56]))
    else $error("reply byte not most significant first");
  a_rx_no_hold: assert property (st_q == SRCP_DATA && rx_vld_q
    |=> cnt_q == $past(cnt_q) + 3'h1 || exec_q)
    else $error("receive held off by transmit");

endmodule : srcp_top

`default_nettype wire

// file: verif/srcp_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "srcp_map.svh"

module srcp_host
(
  // clock
  input  wire logic sys_clk,
  // serial lines
  output var  logic line_q,
  input  wire logic tx_pin_q
);
  localparam int BIT = `SRCP_BIT_FAST;
  int sent_cnt = 0;

  // line idles high: the link is set up before any command
  initial line_q = 1'b1;

  // ----------------------------------------
  // sender: only data lines, never paced
  // one byte at a time, the next only once the previous has left
  // ----------------------------------------
  task automatic send(input logic [7:0] b, input logic stop);
    @(posedge sys_clk);
    line_q <= 1'b0;
    repeat (BIT) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) // lsb first, 8 bits
    begin
      line_q <= b[i];
      repeat (BIT) @(posedge sys_clk);
    end
    sent_cnt++;
    line_q <= stop;
    repeat (BIT) @(posedge sys_clk);
    line_q <= 1'b1;
  endtask : send

  // ----------------------------------------
  // receiver: mid-bit sampling of the reply line
  // ----------------------------------------
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    n  = 0;
    ok = 1'b0;
    b  = 8'h00;
    // wait for the start bit before every byte; a query sends eight bytes
    while (tx_pin_q !== 1'b0 && n < 60 * BIT)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n < 60 * BIT)
    begin
      repeat (BIT / 2) @(negedge sys_clk);
      ok = (tx_pin_q === 1'b0);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT) @(negedge sys_clk);
        b[i] = tx_pin_q;
      end
      repeat (BIT) @(negedge sys_clk);
      ok = ok && (tx_pin_q === 1'b1);
    end
  endtask : recv
endmodule : srcp_host

`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "srcp_map.svh"

module testbench;
  logic        sys_clk      = 1'b0;
  logic        arst_n       = 1'b0;
  logic        ce           = 1'b1;
  logic        rx_pin;
  logic        rate_sel_pin = 1'b0;
  logic        tx_pin_q;
  logic [7:0]  cmd_addr_q;
  logic [2:0]  cmd_len      = 3'h0;
  logic        cmd_query    = 1'b0;
  logic        exec_q;
  logic [2:0]  cmd_rd_idx   = 3'h0;
  logic [7:0]  cmd_rd_byte_q;
  logic        exec_done    = 1'b0;
  logic [63:0] reply_data   = 64'h0;
  logic        busy_q;
  logic        fast_rate_q;
  logic        frame_err_q;
  logic        rx_drop_q;
  int          error_cnt    = 0;
  int          checks       = 0;

  always #2.5 sys_clk = ~sys_clk;

  srcp_top srcp_top_inst (.sys_clk(sys_clk), .arst_n(arst_n), .ce(ce), .rx_pin(rx_pin),
    .rate_sel_pin(rate_sel_pin), .tx_pin_q(tx_pin_q), .cmd_addr_q(cmd_addr_q), .cmd_len(cmd_len),
    .cmd_query(cmd_query), .exec_q(exec_q), .cmd_rd_idx(cmd_rd_idx), .cmd_rd_byte_q(cmd_rd_byte_q),
    .exec_done(exec_done), .reply_data(reply_data), .busy_q(busy_q), .fast_rate_q(fast_rate_q),
    .frame_err_q(frame_err_q), .rx_drop_q(rx_drop_q));

  srcp_host srcp_host_inst (.sys_clk(sys_clk), .line_q(rx_pin), .tx_pin_q(tx_pin_q));

  // ----------------------------------------
  // checking and verdict
  // ----------------------------------------
  task automatic fail(input string m);
    error_cnt++;
    $display("Error at %0t: %s", $time, m);
  endtask : fail

  task automatic chk8(input logic [7:0] got, exp, input string m);
    checks++;
    if (got !== exp) fail(m);
  endtask : chk8

  task automatic chk1(input logic got, exp, input string m);
    checks++;
    if (got !== exp) fail(m);
  endtask : chk1

  task automatic summarize;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  // ----------------------------------------
  // one command: send, execute, collect replies
  // ----------------------------------------
  task automatic cmd(input logic [7:0] a, input logic [2:0] len, input logic q,
                     input logic [55:0] d, input logic [63:0] rep, input int nrep);
    logic [7:0] b;
    logic       ok;
    int         n;
    int         base;
    base = srcp_host_inst.sent_cnt;
    @(posedge sys_clk);
    cmd_len   <= len;
    cmd_query <= q;
    fork
      begin
        srcp_host_inst.send(a, 1'b1);
        for (int i = 0; i < len; i++)
          srcp_host_inst.send(d[55-8*i -: 8], 1'b1);
      end
      begin
        n = 0;
        while (exec_q !== 1'b1 && n < 300000)
        begin
          @(negedge sys_clk);
          n++;
        end
        chk1(exec_q, 1'b1, "no execute pulse");
        chk8(8'(srcp_host_inst.sent_cnt - base), 8'(len + 1), "early execute");
        chk8(cmd_addr_q, a, "address");
        for (int i = 0; i < len; i++)
        begin
          @(posedge sys_clk);
          cmd_rd_idx <= 3'(i);
          @(negedge sys_clk);
          @(negedge sys_clk);
          chk8(cmd_rd_byte_q, d[55-8*i -: 8], "data byte");
        end
        @(posedge sys_clk);
        exec_done  <= 1'b1;
        reply_data <= rep;
        @(posedge sys_clk);
        exec_done  <= 1'b0;
      end
      begin
        for (int k = 0; k < nrep; k++)
        begin
          srcp_host_inst.recv(b, ok);
          chk1(ok, 1'b1, "reply framing");
          chk8(b, q ? rep[63-8*k -: 8] : `SRCP_ACK_BYTE, "reply byte");
        end
        chk1(busy_q, 1'b0, "busy after last reply");
      end
    join // every reply consumed before the next command
  endtask : cmd

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    int         n;
    logic [7:0] b;
    logic       ok;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(negedge sys_clk);
    chk1(fast_rate_q, 1'b1, "fast rate");
    chk1(tx_pin_q, 1'b1, "idle line");
    $display("test reset done");
    cmd(8'h2a, 3'h1, 1'b0, 56'h0, 64'h0, 1);
    $display("test config done");
    cmd(8'h45, 3'h3, 1'b1, 56'ha53c0000000000, 64'h0123456789abcdef, 8);
    $display("test query done");
    // a byte sent while the command executes is dropped, not held off
    @(posedge sys_clk);
    cmd_len   <= 3'h0;
    cmd_query <= 1'b0;
    srcp_host_inst.send(8'h33, 1'b1);
    n = 0;
    fork
      srcp_host_inst.send(8'h77, 1'b1);
      begin
        while (rx_drop_q !== 1'b1 && n < 20000)
        begin
          @(negedge sys_clk);
          n++;
        end
        chk1(rx_drop_q, 1'b1, "byte in execute not dropped");
        chk1(busy_q, 1'b1, "busy low while executing");
      end
    join
    chk8(cmd_addr_q, 8'h33, "dropped byte taken");
    fork
      begin
        @(posedge sys_clk);
        exec_done <= 1'b1;
        @(posedge sys_clk);
        exec_done <= 1'b0;
      end
      begin
        srcp_host_inst.recv(b, ok);
        chk1(ok, 1'b1, "ack framing");
        chk8(b, `SRCP_ACK_BYTE, "ack byte");
      end
    join
    $display("test drop done");
    n = 0;
    fork
      srcp_host_inst.send(8'h5a, 1'b0);
      begin
        while (frame_err_q !== 1'b1 && n < 20000)
        begin
          @(negedge sys_clk);
          n++;
        end
        chk1(frame_err_q, 1'b1, "no frame error");
      end
    join
    chk8(cmd_addr_q, 8'h33, "bad byte taken");
    $display("test framing done");
    @(posedge sys_clk);
    rate_sel_pin <= 1'b1;
    arst_n       <= 1'b0;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(negedge sys_clk);
    chk1(fast_rate_q, 1'b0, "slow rate");
    $display("test rate done");
    summarize();
  end

  // about nineteen characters of ten bit times each, with margin
  initial
  begin
    repeat (450000) @(posedge sys_clk);
    fail("timeout");
    summarize();
  end
endmodule : testbench

`default_nettype wire
